/* design/anp_cfg.svh */
`ifndef ANP_CFG_SVH
`define ANP_CFG_SVH

// register addresses on the management register port
`define ANP_ADDR_W        5
`define ANP_ADDR_EXP      5'h06
`define ANP_ADDR_NP_TX    5'h07
`define ANP_ADDR_NP_LP    5'h08

// expansion register field positions
`define ANP_EXP_LP_AN     0
`define ANP_EXP_PG_RX     1
`define ANP_EXP_NP_ABLE   2
`define ANP_EXP_LP_NP     3
`define ANP_EXP_PD_FLT    4

// next-page word field positions
`define ANP_NP_BIT        15
`define ANP_RSVD_BIT      14
`define ANP_MP_BIT        13
`define ANP_ACK2_BIT      12
`define ANP_TGL_BIT       11
`define ANP_CODE_MSB      10

// reset values
`define ANP_NP_ABLE_RST   1'h1
`define ANP_TX_NP_RST     1'h0
`define ANP_TX_MP_RST     1'h1
`define ANP_TX_ACK2_RST   1'h0
`define ANP_TX_TGL_RST    1'h0
`define ANP_TX_CODE_RST   11'h001
`define ANP_RSVD_RST      1'h0
`define ANP_PULSE_RST     1'h0
`define ANP_FLAG_RST      1'h0
`define ANP_WORD_ZERO     16'h0000

`endif

/* design/anp_pkg.sv */
package anp_pkg;

   typedef struct packed {
      logic        next_page;
      logic        reserved;
      logic        msg_page;
      logic        ack2;
      logic        toggle;
      logic [10:0] code;
   } anp_np_word_type;

   typedef struct packed {
      logic [4:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } anp_reg_req_type;

endpackage

/* design/anp_lh_flag.sv */
`timescale 1ns/1ps
`default_nettype none
`include "anp_cfg.svh"

module anp_lh_flag
(
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic event_i,
   input  wire logic rd_clr_i,
   output logic      flag_o
);

   logic flag_q;
   logic flag_d;

   ////////////////////////////////////////////////////////////////////////
   // set beats the read clear; a level still present re-sets it at once
   always_comb
   begin
      flag_d = event_i | (flag_q & ~rd_clr_i); // [R3] [R10]
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         flag_q <= `ANP_FLAG_RST; // [R3]
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;

endmodule

`default_nettype wire

/* design/anp_regs.sv */
// Notes on behaviour
// [R1] expansion bit 3 shows whether the partner signalled next-page ability, read-only.
// [R2] expansion bit 2 is read-only and always 1, the local side supports next pages.
// [R3] page-received (bit 1) and parallel-fault (bit 4) latch high on their event, reset 0.
// [R4] management writes next-page bit 15, message-page bit 13 (reset 1) and code 10:0 (reset 1).
// [R5] management sets acknowledge-2 bit 12 to say whether it can comply, reset 0.
// [R6] toggle bit 11 is read-only, inverts per sent page, resets 0; bit 14 reads 0.
// [R7] the partner next-page register is read-only, holds the last received page, resets 0.
// [R8] the partner register shows received acknowledge-2 at bit 12 and toggle at bit 11.
// [R9] expansion bits 15 to 5 and all reserved bits read 0 and ignore writes.
// [R10] a latched-high flag clears once read unless its cause is still present.
`timescale 1ns/1ps
`default_nettype none
`include "anp_cfg.svh"

module anp_regs
(
   input  wire logic                     CLK_SYS_I,
   input  wire logic                     NRST_I,
   input  wire anp_pkg::anp_reg_req_type REG_REQ_I,
   output logic [15:0]                   REG_RDATA_O,
   output logic                          REG_RVALID_O,
   input  wire logic                     AN_LP_AN_ABLE_I,
   input  wire logic                     AN_LP_NP_ABLE_I,
   input  wire logic                     AN_PAR_DET_FAULT_I,
   input  wire logic                     AN_PAGE_RX_I,
   input  wire anp_pkg::anp_np_word_type AN_RX_WORD_I,
   input  wire logic                     AN_NP_SENT_I,
   output anp_pkg::anp_np_word_type      NP_TX_WORD_O,
   output logic                          NP_TX_LOADED_O
);
   import anp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ref_a);
      hit = (a == ref_a);
   endfunction

   logic wr_tx;
   logic rd_exp;

   assign wr_tx  = REG_REQ_I.wr & hit(REG_REQ_I.addr, `ANP_ADDR_NP_TX);
   assign rd_exp = REG_REQ_I.rd & hit(REG_REQ_I.addr, `ANP_ADDR_EXP);

   ////////////////////////////////////////////////////////////////////////
   // latched-high event flags

   logic pg_rx_flag;
   logic pd_flt_flag;

   anp_lh_flag u_pg_rx
   (
      .clk_i    (CLK_SYS_I),
      .nrst_i   (NRST_I),
      .event_i  (AN_PAGE_RX_I),
      .rd_clr_i (rd_exp),
      .flag_o   (pg_rx_flag)
   );

   anp_lh_flag u_pd_flt
   (
      .clk_i    (CLK_SYS_I),
      .nrst_i   (NRST_I),
      .event_i  (AN_PAR_DET_FAULT_I),
      .rd_clr_i (rd_exp),
      .flag_o   (pd_flt_flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // next-page transmit word

   anp_np_word_type tx_q;
   anp_np_word_type tx_d;
   anp_np_word_type wr_word;

   assign wr_word = anp_np_word_type'(REG_REQ_I.wdata);

   // a write and a sent page in one cycle both take effect
   always_comb
   begin
      tx_d = tx_q;
      if (wr_tx)
      begin
         tx_d.next_page = wr_word.next_page; // [R4]
         tx_d.msg_page  = wr_word.msg_page; // [R4]
         tx_d.code      = wr_word.code; // [R4]
         tx_d.ack2      = wr_word.ack2; // [R5]
      end
      // toggle is never taken from the bus write
      if (AN_NP_SENT_I)
      begin
         tx_d.toggle = ~tx_q.toggle; // [R6]
      end
      tx_d.reserved = `ANP_RSVD_RST; // [R6] [R9]
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         tx_q.next_page <= `ANP_TX_NP_RST;
         tx_q.reserved  <= `ANP_RSVD_RST;
         tx_q.msg_page  <= `ANP_TX_MP_RST;
         tx_q.ack2      <= `ANP_TX_ACK2_RST;
         tx_q.toggle    <= `ANP_TX_TGL_RST;
         tx_q.code      <= `ANP_TX_CODE_RST;
      end
      else
      begin
         tx_q <= tx_d;
      end
   end

   assign NP_TX_WORD_O = tx_q;

   ////////////////////////////////////////////////////////////////////////
   // one-cycle load strobe towards the negotiation logic

   logic loaded_q;
   logic loaded_d;

   always_comb
   begin
      loaded_d = wr_tx; // [R4]
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         loaded_q <= `ANP_PULSE_RST;
      end
      else
      begin
         loaded_q <= loaded_d;
      end
   end

   assign NP_TX_LOADED_O = loaded_q;

   ////////////////////////////////////////////////////////////////////////
   // last page seen from the link partner

   anp_np_word_type lp_q;
   anp_np_word_type lp_d;

   always_comb
   begin
      lp_d = lp_q;
      if (AN_PAGE_RX_I)
      begin
         lp_d.next_page = AN_RX_WORD_I.next_page; // [R7]
         lp_d.msg_page  = AN_RX_WORD_I.msg_page; // [R7]
         lp_d.ack2      = AN_RX_WORD_I.ack2; // [R8]
         lp_d.toggle    = AN_RX_WORD_I.toggle; // [R8]
         lp_d.code      = AN_RX_WORD_I.code; // [R7]
      end
      // a reserved bit set on the line must not show in the register
      lp_d.reserved = `ANP_RSVD_RST; // [R9]
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         lp_q <= anp_np_word_type'(`ANP_WORD_ZERO); // [R7]
      end
      else
      begin
         lp_q <= lp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, registered; unmapped addresses return zero

   logic [15:0] exp_word;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic        rvalid_q;
   logic        rvalid_d;

   always_comb
   begin
      exp_word                   = `ANP_WORD_ZERO; // [R9]
      exp_word[`ANP_EXP_LP_AN]   = AN_LP_AN_ABLE_I;
      exp_word[`ANP_EXP_PG_RX]   = pg_rx_flag; // [R3]
      exp_word[`ANP_EXP_NP_ABLE] = `ANP_NP_ABLE_RST; // [R2]
      exp_word[`ANP_EXP_LP_NP]   = AN_LP_NP_ABLE_I; // [R1]
      exp_word[`ANP_EXP_PD_FLT]  = pd_flt_flag; // [R3]
   end

   always_comb
   begin
      rdata_d  = rdata_q;
      rvalid_d = REG_REQ_I.rd;
      if (REG_REQ_I.rd)
      begin
         unique case (REG_REQ_I.addr)
            `ANP_ADDR_EXP:   rdata_d = exp_word;
            `ANP_ADDR_NP_TX: rdata_d = tx_q;
            `ANP_ADDR_NP_LP: rdata_d = lp_q; // [R7] [R8]
            default:         rdata_d = `ANP_WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         rdata_q  <= `ANP_WORD_ZERO;
         rvalid_q <= `ANP_PULSE_RST;
      end
      else
      begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign REG_RDATA_O  = rdata_q;
   assign REG_RVALID_O = rvalid_q;

endmodule

`default_nettype wire

/* test/anp_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module anp_regs_props
(
   input wire logic                     CLK_SYS_I,
   input wire logic                     NRST_I,
   input wire anp_pkg::anp_reg_req_type REG_REQ_I,
   input wire logic [15:0]              REG_RDATA_O,
   input wire logic                     AN_LP_NP_ABLE_I,
   input wire logic                     AN_PAR_DET_FAULT_I,
   input wire logic                     AN_PAGE_RX_I,
   input wire anp_pkg::anp_np_word_type AN_RX_WORD_I,
   input wire logic                     AN_NP_SENT_I,
   input wire anp_pkg::anp_np_word_type NP_TX_WORD_O,
   input wire logic                     NP_TX_LOADED_O
);
   import anp_pkg::*;
   logic        rd6;
   logic        pg_q;
   logic        pd_q;
   logic [15:0] lp_q;
   assign rd6 = REG_REQ_I.rd && REG_REQ_I.addr == 5'h06;
   // own copy of the latches: a new event beats the read clear
   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
      if (!NRST_I)
      begin
         pg_q <= 1'h0;
         pd_q <= 1'h0;
         lp_q <= 16'h0000;
      end
      else
      begin
         pg_q <= AN_PAGE_RX_I | (pg_q & !rd6);
         pd_q <= AN_PAR_DET_FAULT_I | (pd_q & !rd6);
         lp_q <= AN_PAGE_RX_I ? (AN_RX_WORD_I & 16'hBFFF) : lp_q;
      end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   property p_lpnp; rd6 |=> REG_RDATA_O[3] == $past(AN_LP_NP_ABLE_I); endproperty
   a_lpnp: assert property (p_lpnp) else $error("partner np bit");
   property p_able; rd6 |=> REG_RDATA_O[2]; endproperty
   a_able: assert property (p_able) else $error("np able bit");
   property p_rsv; rd6 |=> REG_RDATA_O[15:5] == 11'h000; endproperty
   a_rsv: assert property (p_rsv) else $error("expansion high bits");
   property p_pg; rd6 |=> REG_RDATA_O[1] == $past(pg_q); endproperty
   a_pg: assert property (p_pg) else $error("page flag");
   property p_pd; rd6 |=> REG_RDATA_O[4] == $past(pd_q); endproperty
   a_pd: assert property (p_pd) else $error("fault flag");
   property p_wr;
      REG_REQ_I.wr && REG_REQ_I.addr == 5'h07 |=> NP_TX_LOADED_O &&
         (NP_TX_WORD_O & 16'hB7FF) == ($past(REG_REQ_I.wdata) & 16'hB7FF);
   endproperty
   a_wr: assert property (p_wr) else $error("tx word write");
   property p_ld; !(REG_REQ_I.wr && REG_REQ_I.addr == 5'h07) |=> !NP_TX_LOADED_O; endproperty
   a_ld: assert property (p_ld) else $error("load strobe stuck");
   property p_b14; !NP_TX_WORD_O.reserved; endproperty
   a_b14: assert property (p_b14) else $error("tx bit 14");
   property p_tg; AN_NP_SENT_I |=> NP_TX_WORD_O.toggle != $past(NP_TX_WORD_O.toggle); endproperty
   a_tg: assert property (p_tg) else $error("toggle flip");
   property p_tgs; !AN_NP_SENT_I |=> $stable(NP_TX_WORD_O.toggle); endproperty
   a_tgs: assert property (p_tgs) else $error("toggle moved");
   property p_lp;
      REG_REQ_I.rd && REG_REQ_I.addr == 5'h08 |=> REG_RDATA_O == $past(lp_q);
   endproperty
   a_lp: assert property (p_lp) else $error("partner word");
endmodule
`default_nettype wire

/* test/anp_lp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module anp_lp_model
(
   input  wire logic                     clk_i,
   input  wire logic                     nrst_i,
   input  wire logic                     load_i,
   input  wire anp_pkg::anp_np_word_type tx_i,
   output logic                          pg_o,
   output anp_pkg::anp_np_word_type      word_o
);
   import anp_pkg::*;
   logic [2:0] cnt_q;
   // slow answer; word wobbles between pages so stale data shows
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         cnt_q  <= 3'h0;
         pg_o   <= 1'h0;
         word_o <= '0;
      end
      else
      begin
         cnt_q  <= load_i ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
         pg_o   <= cnt_q == 3'h1;
         word_o <= (cnt_q == 3'h1) ? {3'h3, tx_i.ack2, tx_i.toggle, ~tx_i.code} : ~word_o;
      end
endmodule
`default_nettype wire

/* test/anp_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module anp_regs_test;
   import anp_pkg::*;
   logic            clk = 0, nrst = 0, lp_an = 0, lp_np = 0, pdf = 0;
   logic            rvalid, pg, loaded;
   logic [15:0]     rdata;
   anp_reg_req_type req = '0;
   anp_np_word_type rx_word, tx_word;
   int              bad_count = 0, num_checks = 0;
   always #5 clk = ~clk;
   anp_regs u_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
      .REG_RVALID_O(rvalid), .AN_LP_AN_ABLE_I(lp_an), .AN_LP_NP_ABLE_I(lp_np),
      .AN_PAR_DET_FAULT_I(pdf), .AN_PAGE_RX_I(pg), .AN_RX_WORD_I(rx_word),
      .AN_NP_SENT_I(pg), .NP_TX_WORD_O(tx_word), .NP_TX_LOADED_O(loaded));
   anp_lp_model u_lp (.clk_i(clk), .nrst_i(nrst), .load_i(loaded), .tx_i(tx_word),
      .pg_o(pg), .word_o(rx_word));
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk) #1 req = '{a, 1'h1, 1'h0, d};
      @(posedge clk) #1 req = '0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk) #1 req = '{a, 1'h0, 1'h1, 16'h0000};
      `CHK("rvalid idle", 1'h0, rvalid)
      @(posedge clk) #1 req = '0;
      `CHK("rvalid", 1'h1, rvalid)
      `CHK("rdata", e, rdata)
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #50000 bad_count++;
      end_sim;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      #1 nrst = 1;
      rd(5'h06, 16'h0004);
      rd(5'h07, 16'h2001);
      rd(5'h08, 16'h0000);
      rd(5'h1F, 16'h0000);
      lp_an = 1;
      lp_np = 1;
      wr(5'h06, 16'hFFFF);
      rd(5'h06, 16'h000D);
      wr(5'h07, 16'hFFFF);
      rd(5'h07, 16'hB7FF);
      repeat (6) @(posedge clk);
      rd(5'h07, 16'hBFFF);
      rd(5'h06, 16'h000F);
      rd(5'h06, 16'h000D);
      rd(5'h08, 16'h3000);
      @(posedge clk) #1 pdf = 1;
      @(posedge clk) #1 pdf = 0;
      rd(5'h06, 16'h001D);
      rd(5'h06, 16'h000D);
      @(posedge clk) #1 pdf = 1;
      rd(5'h06, 16'h001D);
      rd(5'h06, 16'h001D);
      pdf = 0;
      rd(5'h06, 16'h001D);
      rd(5'h06, 16'h000D);
      wr(5'h07, 16'h0000);
      rd(5'h07, 16'h0800);
      repeat (6) @(posedge clk);
      rd(5'h07, 16'h0000);
      rd(5'h08, 16'h2FFF);
      @(posedge clk) #1 nrst = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      rd(5'h06, 16'h000D);
      rd(5'h07, 16'h2001);
      rd(5'h08, 16'h0000);
      end_sim;
   end
endmodule
bind anp_regs anp_regs_props u_chk
(
   .CLK_SYS_I          (CLK_SYS_I),
   .NRST_I             (NRST_I),
   .REG_REQ_I          (REG_REQ_I),
   .REG_RDATA_O        (REG_RDATA_O),
   .AN_LP_NP_ABLE_I    (AN_LP_NP_ABLE_I),
   .AN_PAR_DET_FAULT_I (AN_PAR_DET_FAULT_I),
   .AN_PAGE_RX_I       (AN_PAGE_RX_I),
   .AN_RX_WORD_I       (AN_RX_WORD_I),
   .AN_NP_SENT_I       (AN_NP_SENT_I),
   .NP_TX_WORD_O       (NP_TX_WORD_O),
   .NP_TX_LOADED_O     (NP_TX_LOADED_O)
);
`default_nettype wire
